//--- hdl/tbs_cycle_meter.sv
// Purpose: actual and maximum duration of one processing pass
// Assumes: us_now wraps; passes shorter than the wrap period
// Notes:   a stop without a preceding start is ignored
`timescale 1ns/1ns
`default_nettype none
module tbs_cycle_meter (
   input  wire logic clk,
   input  wire logic reset,
   tbs_meas_if.meter m
);
   import tbs_pkg::*;
   logic [TW-1:0] t0_r;
   logic          run_r;
   logic [TW-1:0] diff;

   assign diff = m.us_now - t0_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         t0_r     <= '0;
         run_r    <= 1'b0;
         m.actual <= '0;
      end else if (m.start) begin
         t0_r  <= m.us_now;
         run_r <= 1'b1;
      end else if (m.stop && run_r) begin
         m.actual <= diff;
         run_r    <= 1'b0;
      end
   end

   // a pass ending in the clearing cycle still counts as the new maximum
   always_ff @(posedge clk) begin
      if (reset)
         m.maximum <= '0;
      else if (m.stop && run_r && !m.start &&
               (m.clear_max || diff > m.maximum))
         m.maximum <= diff;
      else if (m.clear_max)
         m.maximum <= '0;
   end

   property p_max_covers;
      @(posedge clk) disable iff (reset)
      (m.stop && run_r && !m.start) |=> (m.maximum >= m.actual);
   endproperty
   a_max_covers: assert property (p_max_covers)
      else $error("maximum below actual after a pass");

   property p_clear;
      @(posedge clk) disable iff (reset)
      (m.clear_max && !m.stop) |=> (m.maximum == '0);
   endproperty
   a_clear: assert property (p_clear)
      else $error("maximum not cleared");
endmodule : tbs_cycle_meter
`default_nettype wire

//--- hdl/tbs_supervisor.sv
// Purpose: terminal bus supervisor: start-up check, exchange gating,
//          watchdog, input and output fallback, cycle-time figures
// Assumes: term_* inputs come from the bus pins and are synchronised
// Notes:   settings take effect at reset or restart_req only
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - store terminal set on boot project creation, compare on restart
// - failed start-up check blocks exchange and program start
// - auto recovery resumes exchange and outputs when bus error clears
// - zero-on-halt stops bus service at breakpoint, outputs zero
// - terminal cycles follow task 1 or fieldbus per sync selection
// - delayed bus service trips watchdog and drops outputs
// - default re-arms watchdog three times at 85 ms steps
// - re-arm 0 gives 100 ms, 1..3 give 2..4 times 85 ms
// - bus error zeroes or holds terminal inputs per selection
// - program stop clears or keeps fieldbus output data per policy
// - report actual and maximum times: task 1, bus, fieldbus, sub-bus
// - reset-maximum command clears all maxima; one whose pass ends in that cycle takes that pass time
// - factory defaults apply only after restart; a reset discards a pending request
// - multi-byte structures sit on word-aligned image offsets
module tbs_supervisor (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire tbs_pkg::tbs_cfg_t    cfg_req,
   input  wire logic                 restart_req,
   input  wire logic                 boot_project_create,
   input  wire logic                 factory_defaults,
   input  wire logic                 clear_max_req,
   input  wire logic                 term_chain_ok,
   input  wire logic [tbs_pkg::SW-1:0] term_signature,
   input  wire logic                 term_error,
   input  wire logic                 term_cycle_done,
   input  wire logic [tbs_pkg::DW-1:0] term_in_data,
   output logic                      term_cycle_start,
   output logic                      term_out_enable,
   output logic [tbs_pkg::DW-1:0]    term_out_data,
   input  wire logic                 task1_tick,
   input  wire logic                 task1_done,
   input  wire logic                 fieldbus_tick,
   input  wire logic                 fieldbus_done,
   input  wire logic                 sub_bus_start,
   input  wire logic                 sub_bus_done,
   input  wire logic                 prog_running,
   input  wire logic                 prog_halted,
   input  wire logic [tbs_pkg::DW-1:0] prog_out_data,
   input  wire logic [tbs_pkg::DW-1:0] prog_fb_data,
   input  wire logic [tbs_pkg::AW-1:0] struct_offset_req,
   output logic [tbs_pkg::AW-1:0]    struct_offset,
   output logic [tbs_pkg::DW-1:0]    in_image,
   output logic [tbs_pkg::DW-1:0]    fb_out_data,
   output logic                      prog_enable,
   output logic                      exchange_active,
   output logic                      check_failed,
   output var tbs_pkg::tbs_cfg_t     cfg_active,
   output logic                      defaults_pending,
   output logic                      watchdog_tripped,
   output logic [tbs_pkg::TW-1:0]    time_actual [tbs_pkg::NMEAS],
   output logic [tbs_pkg::TW-1:0]    time_max    [tbs_pkg::NMEAS]
);
   import tbs_pkg::*;

   localparam int PW = 1 + SW + 1 + 1 + DW;

   tbs_state_t     state_r;
   logic [PW-1:0]  pin_meta_r;
   logic [PW-1:0]  pin_sync_r;
   logic           chain_ok_s;
   logic [SW-1:0]  sig_s;
   logic           err_s;
   logic           done_s;
   logic [DW-1:0]  din_s;
   logic [SW-1:0]  stored_sig_r;
   logic           busy_r;
   logic           cycle_trig;
   logic           halt_block;
   logic           wd_expired;
   logic [6:0]     us_div_r;
   logic [9:0]     ms_div_r;
   logic           ms_tick_r;
   logic [TW-1:0]  us_now_r;

   // first stage feeds only the second; no reset here, so the pins are
   // flushed through while reset is held and the start-up check that
   // follows the release sees real values, not a cleared chain
   always_ff @(posedge clk) begin
      pin_meta_r <= {term_chain_ok, term_signature, term_error,
                     term_cycle_done, term_in_data};
      pin_sync_r <= pin_meta_r;
   end
   assign {chain_ok_s, sig_s, err_s, done_s, din_s} = pin_sync_r;

   // time base: microsecond count and millisecond tick
   always_ff @(posedge clk) begin
      if (reset) begin
         us_div_r  <= '0;
         ms_div_r  <= '0;
         us_now_r  <= '0;
         ms_tick_r <= 1'b0;
      end else begin
         ms_tick_r <= 1'b0;
         if (us_div_r == 7'(US_CYC - 1)) begin
            us_div_r <= '0;
            us_now_r <= us_now_r + 1'b1;
            if (ms_div_r == 10'(MS_US - 1)) begin
               ms_div_r  <= '0;
               ms_tick_r <= 1'b1;
            end else begin
               ms_div_r <= ms_div_r + 1'b1;
            end
         end else begin
            us_div_r <= us_div_r + 1'b1;
         end
      end
   end

   // factory defaults wait for the next boot; cleared by reset or once the
   // boot state has used them, and a request in that cycle is kept
   always_ff @(posedge clk) begin
      if (reset)
         defaults_pending <= 1'b0;
      else if (factory_defaults)
         defaults_pending <= 1'b1;
      else if (state_r == ST_BOOT)
         defaults_pending <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset)
         cfg_active <= CFG_DEFAULT;
      else if (state_r == ST_BOOT)
         cfg_active <= defaults_pending ? CFG_DEFAULT : cfg_req;
   end

   always_ff @(posedge clk) begin
      if (reset)
         stored_sig_r <= '0;
      else if (boot_project_create)
         stored_sig_r <= sig_s;
   end

   assign halt_block = cfg_active.zero_on_halt && prog_halted;
   assign cycle_trig = cfg_active.sync_fieldbus ? fieldbus_tick
                                                : task1_tick;

   always_ff @(posedge clk) begin
      if (reset || restart_req) begin
         state_r      <= ST_BOOT;
         check_failed <= 1'b0;
      end else begin
         case (state_r)
            ST_BOOT:  state_r <= ST_CHECK;
            ST_CHECK: begin
               if (!chain_ok_s) begin
                  state_r <= ST_BLOCK;
               end else if (cfg_active.check_start &&
                            sig_s != stored_sig_r) begin
                  state_r      <= ST_BLOCK;
                  check_failed <= 1'b1;
               end else begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (err_s || wd_expired || !chain_ok_s)
                  state_r <= ST_ERROR;
            end
            ST_ERROR: begin
               if (cfg_active.auto_recover && !err_s && chain_ok_s)
                  state_r <= ST_RUN;
            end
            ST_BLOCK: state_r <= ST_BLOCK;
            default:  state_r <= ST_BOOT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_r != ST_RUN) begin
         busy_r           <= 1'b0;
         term_cycle_start <= 1'b0;
      end else begin
         term_cycle_start <= 1'b0;
         if (cycle_trig && !busy_r && !halt_block) begin
            term_cycle_start <= 1'b1;
            busy_r           <= 1'b1;
         end else if (done_s) begin
            busy_r <= 1'b0;
         end
      end
   end

   tbs_watchdog u_wd (
      .clk         (clk),
      .reset       (reset),
      .ms_tick     (ms_tick_r),
      .arm         (state_r == ST_RUN),
      .cycle_done  (done_s && busy_r),
      .rearm_count (cfg_active.watchdog_rearm_count),
      .expired     (wd_expired)
   );

   always_ff @(posedge clk) begin
      if (reset || state_r == ST_BOOT)
         watchdog_tripped <= 1'b0;
      else if (state_r == ST_RUN && wd_expired)
         watchdog_tripped <= 1'b1;
   end

   assign exchange_active = (state_r == ST_RUN) && !halt_block;
   assign prog_enable     = (state_r == ST_RUN) || (state_r == ST_ERROR);

   // outputs follow the program one cycle after ST_RUN is re-entered on recovery
   always_ff @(posedge clk) begin
      if (reset) begin
         term_out_enable <= 1'b0;
         term_out_data   <= '0;
      end else if (state_r == ST_RUN && !halt_block && !err_s &&
                   !wd_expired) begin
         term_out_enable <= 1'b1;
         term_out_data   <= prog_out_data;
      end else begin
         term_out_enable <= 1'b0;
         term_out_data   <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         in_image <= '0;
      else if (state_r == ST_ERROR || err_s) begin
         if (!cfg_active.input_hold)
            in_image <= '0;
      end else if (state_r == ST_RUN && done_s && busy_r)
         in_image <= din_s;
   end

   always_ff @(posedge clk) begin
      if (reset)
         fb_out_data <= '0;
      else if (prog_running)
         fb_out_data <= prog_fb_data;
      else if (!cfg_active.stop_output_policy)
         fb_out_data <= '0;
   end

   // word alignment: round the offset up to the next even byte
   always_ff @(posedge clk) begin
      if (reset)
         struct_offset <= '0;
      else
         struct_offset <= (struct_offset_req + 1'b1) & ~AW'(1);
   end

   tbs_meas_if mi [NMEAS] ();

   assign mi[M_TASK1].start = task1_tick;
   assign mi[M_TASK1].stop  = task1_done;
   assign mi[M_TERM].start  = term_cycle_start;
   assign mi[M_TERM].stop   = done_s && busy_r;
   assign mi[M_FB].start    = fieldbus_tick;
   assign mi[M_FB].stop     = fieldbus_done;
   assign mi[M_SUB].start   = sub_bus_start;
   assign mi[M_SUB].stop    = sub_bus_done;

   for (genvar g = 0; g < NMEAS; g++) begin : g_meas
      assign mi[g].us_now    = us_now_r;
      assign mi[g].clear_max = clear_max_req;
      assign time_actual[g]  = mi[g].actual;
      assign time_max[g]     = mi[g].maximum;
      tbs_cycle_meter u_meter (
         .clk   (clk),
         .reset (reset),
         .m     (mi[g])
      );
   end

   property p_block_holds;
      @(posedge clk) disable iff (reset || restart_req)
      (state_r == ST_BLOCK) |=> (state_r == ST_BLOCK) && !prog_enable
                                 && !term_cycle_start;
   endproperty
   a_block_holds: assert property (p_block_holds)
      else $error("blocked start-up left the blocked state");

   property p_chain_needed;
      @(posedge clk) disable iff (reset || restart_req)
      (state_r == ST_CHECK && !chain_ok_s) |=> (state_r == ST_BLOCK);
   endproperty
   a_chain_needed: assert property (p_chain_needed)
      else $error("incomplete terminal chain accepted");

   sequence s_err_cleared;
      (state_r == ST_ERROR) && cfg_active.auto_recover && !err_s
      && chain_ok_s;
   endsequence
   property p_recover;
      @(posedge clk) disable iff (reset || restart_req)
      s_err_cleared |=> (state_r == ST_RUN);
   endproperty
   a_recover: assert property (p_recover)
      else $error("no automatic recovery after bus error");

   property p_halt_zero;
      @(posedge clk) disable iff (reset)
      halt_block |=> !term_out_enable && (term_out_data == '0)
                     && !term_cycle_start;
   endproperty
   a_halt_zero: assert property (p_halt_zero)
      else $error("bus serviced during breakpoint");

   property p_sync_source;
      @(posedge clk) disable iff (reset)
      $rose(term_cycle_start) |-> $past(cfg_active.sync_fieldbus ?
                                  fieldbus_tick : task1_tick);
   endproperty
   a_sync_source: assert property (p_sync_source)
      else $error("terminal cycle not from the selected source");

   property p_wd_drop;
      @(posedge clk) disable iff (reset)
      (state_r == ST_RUN && wd_expired) |=> !term_out_enable;
   endproperty
   a_wd_drop: assert property (p_wd_drop)
      else $error("outputs kept after watchdog expiry");

   property p_in_zero;
      @(posedge clk) disable iff (reset)
      (err_s && !cfg_active.input_hold) |=> (in_image == '0);
   endproperty
   a_in_zero: assert property (p_in_zero)
      else $error("inputs not zeroed on bus error");

   property p_stop_clear;
      @(posedge clk) disable iff (reset)
      (!prog_running && !cfg_active.stop_output_policy)
      |=> (fb_out_data == '0);
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("fieldbus outputs not cleared on stop");

   property p_align;
      @(posedge clk) disable iff (reset)
      ##1 !struct_offset[0];
   endproperty
   a_align: assert property (p_align)
      else $error("structure offset not word aligned");
endmodule : tbs_supervisor
`default_nettype wire

//--- hdl/tbs_watchdog.sv
// Purpose: terminal watchdog with re-arm count selection
// Assumes: ms_tick is one pulse per millisecond
// Notes:   disarmed and cleared whenever arm is low (supervisor outside ST_RUN, so still armed during a halt)
`timescale 1ns/1ns
`default_nettype none
module tbs_watchdog (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       ms_tick,
   input  wire logic       arm,
   input  wire logic       cycle_done,
   input  wire logic [1:0] rearm_count,
   output logic            expired
);
   import tbs_pkg::*;
   logic [MSW-1:0] ms_r;
   logic [MSW-1:0] limit;

   // setting 0 is the bare watchdog; n adds n re-arms of one step each
   always_comb begin
      if (rearm_count == 2'h0)
         limit = MSW'(WD_BASE_MS);
      else
         limit = MSW'(WD_STEP_MS) * (MSW'(rearm_count) + 1'b1);
   end

   always_ff @(posedge clk) begin
      if (reset || !arm || cycle_done)
         ms_r <= '0;
      else if (ms_tick && !expired)
         ms_r <= ms_r + 1'b1;
   end

   assign expired = (ms_r >= limit);

   property p_trip_at_limit;
      @(posedge clk) disable iff (reset)
      $rose(expired) |-> ($past(ms_r) == limit - 1'b1);
   endproperty
   a_trip_at_limit: assert property (p_trip_at_limit)
      else $error("watchdog tripped at the wrong count");

   property p_done_clears;
      @(posedge clk) disable iff (reset)
      cycle_done |=> (ms_r == '0) && !expired;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("completed cycle did not clear the watchdog");
endmodule : tbs_watchdog
`default_nettype wire

//--- pkg/tbs_meas_if.sv
// Purpose: carrier between supervisor and one cycle-time meter
// Assumes: start and stop are single-cycle pulses
// Notes:   us_now is the shared free-running microsecond count
`timescale 1ns/1ns
`default_nettype none
interface tbs_meas_if;
   import tbs_pkg::*;
   logic          start;
   logic          stop;
   logic          clear_max;
   logic [TW-1:0] us_now;
   logic [TW-1:0] actual;
   logic [TW-1:0] maximum;
   modport meter (input start, stop, clear_max, us_now,
                  output actual, maximum);
   modport owner (output start, stop, clear_max, us_now,
                  input actual, maximum);
endinterface : tbs_meas_if
`default_nettype wire

//--- pkg/tbs_pkg.sv
// Purpose: shared constants and types of the terminal bus supervisor
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   all times are derived from the clock period below
package tbs_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int US_NS         = 1000;
   localparam int US_CYC        = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_US         = 1000;
   localparam int WD_BASE_MS    = 100;
   localparam int WD_STEP_MS    = 85;
   localparam int MSW           = 10;
   localparam int DW            = 16;
   localparam int TW            = 16;
   localparam int SW            = 16;
   localparam int AW            = 8;
   localparam int NMEAS         = 4;
   localparam int M_TASK1       = 0;
   localparam int M_TERM        = 1;
   localparam int M_FB          = 2;
   localparam int M_SUB         = 3;

   typedef struct packed {
      logic       check_start;
      logic       auto_recover;
      logic       zero_on_halt;
      logic       sync_fieldbus;
      logic [1:0] watchdog_rearm_count;
      logic       input_hold;
      logic       stop_output_policy;
   } tbs_cfg_t;

   // delivery defaults: no start-up check, no auto recovery, three re-arms
   localparam tbs_cfg_t CFG_DEFAULT = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h3,
                                        1'b0, 1'b0};

   typedef enum logic [2:0] {
      ST_BOOT  = 3'b000,
      ST_CHECK = 3'b001,
      ST_RUN   = 3'b010,
      ST_ERROR = 3'b011,
      ST_BLOCK = 3'b100
   } tbs_state_t;
endpackage : tbs_pkg

//--- testbench/tb.sv
// Purpose: self-checking bench of the terminal bus supervisor
// Assumes: inputs change on the falling edge of a 50 MHz clock
// Notes:   watchdog expiry takes millions of cycles, left to assertions
`timescale 1ns/1ns
`default_nettype none
module tb;
   import tbs_pkg::*;
   logic clk, reset, restart_req, boot_project_create, factory_defaults;
   logic clear_max_req, term_chain_ok, term_error, term_cycle_done;
   logic task1_tick, task1_done, fieldbus_tick, fieldbus_done, fitted;
   logic sub_bus_start, sub_bus_done, prog_running, prog_halted;
   logic term_cycle_start, term_out_enable, prog_enable, exchange_active;
   logic check_failed, defaults_pending, watchdog_tripped;
   logic [7:0]    lat;
   logic [SW-1:0] term_signature;
   logic [DW-1:0] term_in_data, term_out_data, prog_out_data, in_value;
   logic [DW-1:0] prog_fb_data, in_image, fb_out_data;
   logic [AW-1:0] struct_offset_req, struct_offset;
   logic [TW-1:0] time_actual [NMEAS];
   logic [TW-1:0] time_max [NMEAS];
   tbs_cfg_t      cfg_req, cfg_active;
   int            fails = 0;
   int            compares = 0;

   tbs_supervisor tbs_supervisor_inst (.clk, .reset, .cfg_req,
      .restart_req, .boot_project_create, .factory_defaults,
      .clear_max_req, .term_chain_ok, .term_signature, .term_error,
      .term_cycle_done, .term_in_data, .term_cycle_start,
      .term_out_enable, .term_out_data, .task1_tick, .task1_done,
      .fieldbus_tick, .fieldbus_done, .sub_bus_start, .sub_bus_done,
      .prog_running, .prog_halted, .prog_out_data, .prog_fb_data,
      .struct_offset_req, .struct_offset, .in_image, .fb_out_data,
      .prog_enable, .exchange_active, .check_failed, .cfg_active,
      .defaults_pending, .watchdog_tripped, .time_actual, .time_max);

   tbs_term_chain tbs_term_chain_inst (.clk, .term_cycle_start, .lat,
      .in_value, .fitted, .term_chain_ok, .term_cycle_done,
      .term_in_data);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic results;
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   // settings latch only at boot, so every mode change is a restart
   task automatic boot(input logic [7:0] c);
      cfg_req     = tbs_cfg_t'(c);
      restart_req = 1'b1;
      idle(1);
      restart_req = 1'b0;
      idle(5);
   endtask : boot

   task automatic tcyc(input logic fb, input logic [15:0] v,
                       input int exp);
      int n;
      n = 0;
      in_value = v;
      if (fb) fieldbus_tick = 1'b1;
      else task1_tick = 1'b1;
      idle(1);
      fieldbus_tick = 1'b0;
      task1_tick    = 1'b0;
      repeat (4) begin
         if (term_cycle_start === 1'b1) n++;
         idle(1);
      end
      chk(16'(n), 16'(exp));
      idle(int'(lat) + 6);
   endtask : tcyc

   task automatic pass(input int idx, input int us);
      case (idx)
         0: task1_tick = 1'b1;
         2: fieldbus_tick = 1'b1;
         default: sub_bus_start = 1'b1;
      endcase
      idle(1);
      {task1_tick, fieldbus_tick, sub_bus_start} = 3'h0;
      idle(us * US_CYC - 1);
      case (idx)
         0: task1_done = 1'b1;
         2: fieldbus_done = 1'b1;
         default: sub_bus_done = 1'b1;
      endcase
      idle(1);
      {task1_done, fieldbus_done, sub_bus_done} = 3'h0;
      idle(3);
      chk(time_actual[idx], 16'(us));
   endtask : pass

   initial begin
      #1_000_000;
      fails++;
      results();
   end

   initial begin
      reset = 1'b1;
      cfg_req = CFG_DEFAULT;
      {restart_req, boot_project_create, factory_defaults} = 3'h0;
      {clear_max_req, term_error, task1_tick, task1_done} = 4'h0;
      {fieldbus_tick, fieldbus_done, sub_bus_start, sub_bus_done} = 4'h0;
      {prog_halted, prog_running, fitted} = 3'h3;
      lat = 8'h03;
      in_value = 16'hA5A5;
      term_signature = 16'h1234;
      prog_out_data = 16'h5A3C;
      prog_fb_data = 16'h0F0F;
      struct_offset_req = 8'h00;
      idle(2);
      chk(cfg_active, CFG_DEFAULT);
      idle(3);
      reset = 1'b0;
      idle(5);
      chk(prog_enable, 1'b1);
      chk(term_out_enable, 1'b1);
      chk(term_out_data, 16'h5A3C);
      chk(watchdog_tripped, 1'b0);
      tcyc(1'b0, 16'h1357, 1);
      chk(in_image, 16'h1357);
      tcyc(1'b1, 16'h2468, 0);
      lat = 8'h28;
      tcyc(1'b0, 16'h9ABC, 1);
      chk(in_image, 16'h9ABC);
      lat = 8'h03;
      boot(8'h1C);
      tcyc(1'b0, 16'h2222, 0);
      tcyc(1'b1, 16'h3333, 1);
      boot(8'h4C);
      term_error = 1'b1;
      idle(6);
      chk(term_out_enable, 1'b0);
      chk(in_image, 16'h0000);
      term_error = 1'b0;
      idle(6);
      chk(term_out_enable, 1'b1);
      boot(8'h0E);
      tcyc(1'b0, 16'hBEEF, 1);
      term_error = 1'b1;
      idle(6);
      chk(in_image, 16'hBEEF);
      term_error = 1'b0;
      idle(6);
      chk(term_out_enable, 1'b0);
      boot(8'h2C);
      prog_halted = 1'b1;
      idle(4);
      chk(exchange_active, 1'b0);
      chk(term_out_enable, 1'b0);
      tcyc(1'b0, 16'h1111, 0);
      prog_halted = 1'b0;
      idle(4);
      chk(term_out_enable, 1'b1);
      boot(8'h0C);
      prog_running = 1'b0;
      idle(3);
      chk(fb_out_data, 16'h0000);
      boot(8'h0D);
      prog_running = 1'b1;
      idle(3);
      prog_running = 1'b0;
      prog_fb_data = 16'h7777;
      idle(3);
      chk(fb_out_data, 16'h0F0F);
      prog_running = 1'b1;
      boot_project_create = 1'b1;
      idle(1);
      boot_project_create = 1'b0;
      term_signature = 16'h4321;
      idle(4);
      boot(8'h8C);
      chk(check_failed, 1'b1);
      chk(prog_enable, 1'b0);
      chk(exchange_active, 1'b0);
      term_signature = 16'h1234;
      idle(4);
      boot(8'h8C);
      chk(check_failed, 1'b0);
      chk(prog_enable, 1'b1);
      fitted = 1'b0;
      idle(4);
      boot(8'h0C);
      chk(prog_enable, 1'b0);
      fitted = 1'b1;
      idle(4);
      boot(8'h0C);
      pass(0, 5);
      pass(0, 2);
      chk(time_max[0], 16'h0005);
      pass(2, 3);
      pass(3, 4);
      chk(time_max[3], 16'h0004);
      clear_max_req = 1'b1;
      idle(1);
      clear_max_req = 1'b0;
      idle(2);
      for (int i = 0; i < NMEAS; i++) chk(time_max[i], 16'h0000);
      struct_offset_req = 8'h05;
      idle(2);
      chk(struct_offset, 8'h06);
      struct_offset_req = 8'h04;
      idle(2);
      chk(struct_offset, 8'h04);
      boot(8'h4D);
      factory_defaults = 1'b1;
      idle(1);
      factory_defaults = 1'b0;
      idle(2);
      chk(defaults_pending, 1'b1);
      chk(cfg_active, 8'h4D);
      boot(8'h4D);
      chk(cfg_active, CFG_DEFAULT);
      chk(defaults_pending, 1'b0);
      results();
   end
endmodule : tb
`default_nettype wire

//--- testbench/tbs_term_chain.sv
// Purpose: behavioural chain of terminals ending in the end terminal
// Assumes: term_cycle_start is a one-cycle pulse; lat is at least 2
// Notes:   data shows the inverse outside its window so stale reads show
`timescale 1ns/1ns
`default_nettype none
module tbs_term_chain
   import tbs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          term_cycle_start,
   input  wire logic [7:0]    lat,
   input  wire logic [DW-1:0] in_value,
   input  wire logic          fitted,
   output logic               term_chain_ok,
   output logic               term_cycle_done,
   output logic [DW-1:0]      term_in_data
);
   int   cnt = 0;
   logic valid = 1'b0;

   initial term_cycle_done = 1'b0;

   // a process-data terminal plus end terminal only when fitted
   assign term_chain_ok = fitted;
   assign term_in_data  = valid ? in_value : ~in_value;

   always @(posedge clk) begin
      valid           <= (cnt == 2) || (cnt == 1);
      term_cycle_done <= (cnt == 1);
      if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (term_cycle_start) begin
         cnt <= int'(lat) + 1;
      end
   end
endmodule : tbs_term_chain
`default_nettype wire
